/* logic/tmw_defines.svh */
// Register offsets, reset values and field positions for the timer watchdog unit.
`ifndef TMW_DEFINES_SVH
`define TMW_DEFINES_SVH
`define TMW_ADDR_EXT_IRQ_VECTOR_REG 8'hF6
`define TMW_ADDR_FLAG 8'hF2
`define TMW_ADDR_CNTH 8'hF8
`define TMW_ADDR_CNTL 8'hF9
`define TMW_ADDR_PRE 8'hFA
`define TMW_ADDR_CTRL 8'hFB
`define TMW_ADDR_WAIT 8'hFC
`define TMW_RST_CNT 16'hFFFF
`define TMW_RST_PRE 8'hFF
`define TMW_RST_CTRL 8'h12
`define TMW_RST_WAIT 8'h7F
`define TMW_RST_EXT_IRQ_VECTOR_REG 8'h06
`define TMW_KEY_ARM 8'hAA
`define TMW_KEY_FIRE 8'h55
`define TMW_CTRL_RUN 7
`define TMW_CTRL_SINGLE 6
`define TMW_CTRL_MODE_HI 5
`define TMW_CTRL_MODE_LO 4
`define TMW_CTRL_INPUT_SECTION_ENABLE 3
`define TMW_CTRL_OUTPUT_MODE_BIT 2
`define TMW_CTRL_WRITE_OUT_BIT 1
`define TMW_CTRL_OUTPUT_ENABLE_BIT 0
`define TMW_WAIT_GEN_N 6
`define TMW_EXT_IRQ_VECTOR_REG_TLS 2
`define TMW_EXT_IRQ_VECTOR_REG_A0S 1
`define TMW_FLAG_GRES 6
`define TMW_CLK_DIV 2'h3
`endif

/* logic/tmw_pkg.sv */
// Types shared by the timer watchdog unit.
package tmw_pkg;
  typedef enum logic [1:0] {
    TMW_IN_EVENT = 2'h0,
    TMW_IN_GATED = 2'h1,
    TMW_IN_TRIG = 2'h2,
    TMW_IN_RETRIG = 2'h3
  } tmw_in_mode_t;
  typedef enum logic [2:0] {
    TMW_ST_IDLE = 3'b001,
    TMW_ST_ARMED = 3'b010,
    TMW_ST_COUNT = 3'b100
  } tmw_state_t;
endpackage

/* logic/tmw_timer_watchdog_unit.sv */
// Timer watchdog unit: 16-bit down counter, prescaler, input modes, output pin and watchdog.
`timescale 1ns/1ps
`include "tmw_defines.svh"
module tmw_timer_watchdog_unit import tmw_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ext_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_event_input_pin,
  input wire logic i_guard_strap_pin,
  input wire logic i_halt_req,
  output logic [7:0] o_reg_rdata,
  output logic o_timer_output_pin,
  output logic o_irq_channel_a0,
  output logic o_irq_top_level,
  output logic o_sys_reset,
  output logic o_guard_mode
);

  // Overview of operation.
  // The counter is sixteen bits wide and counts down, fed by a source pulse through an eight-bit prescaler.
  // The source pulse is the core clock divided by four, taken from a free-running two-bit divider.
  // With the input section enabled, the event pin selects or qualifies that pulse according to the input mode.
  // Event mode uses each falling edge of the pin as the source pulse instead of the divider.
  // Gated mode passes the divider pulse only while the pin is high, so the count holds while it is low.
  // Triggerable and event modes park in an armed state until the first falling edge after run is set.
  // Retriggerable mode reloads the constant on every falling edge seen while the run bit is set.
  // Edges seen while the run bit is clear are dropped, so a stopped timer never restarts by itself.
  // The prescaler counts source pulses down from its value, so a value of n divides by n plus one.
  // A step of the counter while it already holds zero is the end of count.
  // At end of count the counter reloads from the stored constant and the prescaler restarts.
  // In single mode the end of count also clears the run bit; continuous mode keeps counting.
  // Writes to the counter bytes change only the stored constant, never the live count.
  // A constant written while stopped is loaded when counting restarts, so a stale count is not resumed.
  // A constant written while running waits for the next end of count, where the reload path takes it.
  // The prescaler value is written straight into the prescaler count as well, so it acts at once.
  // The output pin is high while disabled, so other functions sharing the pin can still pull it low.
  // Square wave mode toggles the pin at every end of count, giving half the end-of-count rate.
  // Pulse width mode copies the write-out bit to the pin at every end of count and holds it there.
  // Software shapes the pulse width by changing the write-out bit between two ends of count.
  // The timer interrupt goes to channel A0 or to the top level according to the two select bits.
  // When both selects pick the timer, only channel A0 is raised, to avoid a double request.
  // Watchdog mode is entered by the strap at an external reset or by clearing the enable bit.
  // Once entered by software it cannot be left, since setting the enable bit again is never taken.
  // With the strap low the constant is pinned to all ones, and the enable bit has no effect.
  // In watchdog mode the run, single and input mode bits are ignored and counting is continuous.
  // Counter writes are refused there; only the prescaler may still change.
  // The key pair written to the low counter byte reloads the counter and restarts the count.
  // Any other write to the low byte disarms the key, so no other low-byte write may come between the pair.
  // An end of count in watchdog mode raises the system reset pulse and sets the reset flag.
  // The reset flag survives the system reset it causes and is cleared only by an external reset.
  // The halt request is not used at all, because the watchdog must keep counting through a halt.
  // Limitation: the event pin is taken as synchronous; an asynchronous source needs a synchroniser outside.
  // Limitation: the output pin keeps toggling in watchdog mode if enabled, which carries no meaning there.
  // Every output comes straight from a flip-flop, so the far side never sees decode glitches.

  // Register state.
  // Each register below is written by exactly one clocked process.
  // Next values ending in _d come from the combinational processes further down.
  logic [15:0] const_q, const_d;
  logic [15:0] cnt_q, cnt_d;
  logic const_new_q, const_new_d;
  logic [7:0] pre_q;
  logic [7:0] pre_cnt_q, pre_cnt_d;
  logic [1:0] div_q;
  logic [7:0] ctrl_q, ctrl_d;
  logic gen_n_q;
  logic [2:1] ext_irq_vector_reg_q;
  logic gres_q;
  logic hw_guard_q;
  logic guard_q; // Registered copy of the watchdog mode for the output.
  logic pin_q;
  logic key_armed_q;
  logic out_q;
  logic irq_a0_q, irq_tl_q, sys_rst_q;
  logic [7:0] rdata_q;
  tmw_state_t st_q, st_d;

  // Decode of the register bus.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction
  wire logic wr_cnth = i_reg_wr && hit(i_reg_addr, `TMW_ADDR_CNTH);
  wire logic wr_cntl = i_reg_wr && hit(i_reg_addr, `TMW_ADDR_CNTL);
  wire logic wr_pre = i_reg_wr && hit(i_reg_addr, `TMW_ADDR_PRE);
  wire logic wr_ctrl = i_reg_wr && hit(i_reg_addr, `TMW_ADDR_CTRL);
  wire logic wr_wait = i_reg_wr && hit(i_reg_addr, `TMW_ADDR_WAIT);
  wire logic wr_ext_irq_vector_reg = i_reg_wr && hit(i_reg_addr, `TMW_ADDR_EXT_IRQ_VECTOR_REG);

  // Next values of the two watchdog enables, shared by the enables and by the registered mode output.
  wire logic hw_guard_d = i_ext_rst ? !i_guard_strap_pin : hw_guard_q;
  wire logic gen_n_d = (wr_wait && !i_reg_wdata[`TMW_WAIT_GEN_N]) ? 1'b0 : gen_n_q;

  // Mode decode; the strap wins over the software enable bit.
  wire logic guard = hw_guard_q || !gen_n_q;
  wire logic run = ctrl_q[`TMW_CTRL_RUN];
  wire tmw_in_mode_t mode = tmw_in_mode_t'(ctrl_q[`TMW_CTRL_MODE_HI:`TMW_CTRL_MODE_LO]);
  wire logic input_section_enable = ctrl_q[`TMW_CTRL_INPUT_SECTION_ENABLE] && !guard;
  wire logic fall = pin_q && !i_event_input_pin;
  wire logic tick4 = (div_q == `TMW_CLK_DIV);
  wire logic pre_done = (pre_cnt_q == 8'h00);

  // Counting is allowed when running (or in watchdog, which ignores the run bit).
  wire logic active = guard || run;
  // Count-source pulse before the prescaler.
  // Triggerable and retriggerable modes use the divider; their start conditions live in the state machine.
  wire logic src_tick = guard ? tick4 :
                        !input_section_enable ? tick4 :
                        (mode == TMW_IN_EVENT) ? fall :
                        (mode == TMW_IN_GATED) ? (tick4 && i_event_input_pin) :
                        tick4;
  wire logic counting = active && (st_q == TMW_ST_COUNT);
  wire logic cnt_step = counting && src_tick && pre_done;
  wire logic eoc = cnt_step && (cnt_q == 16'h0000);
  wire logic refresh = wr_cntl && key_armed_q && (i_reg_wdata == `TMW_KEY_FIRE) && guard;
  wire logic retrig = !guard && input_section_enable && (mode == TMW_IN_RETRIG) && run && fall;

  // Start/arm state: triggerable and event modes wait for the first falling edge.
  // The armed state keeps an edge that came before the run bit from starting the count.
  // Watchdog mode bypasses arming, since it must count no matter how the timer was left.
  always_comb begin
    st_d = st_q;
    case (st_q)
      TMW_ST_IDLE: begin
        if (guard) begin
          st_d = TMW_ST_COUNT;
        end else if (run) begin
          st_d = (input_section_enable && (mode == TMW_IN_TRIG || mode == TMW_IN_EVENT)) ? TMW_ST_ARMED : TMW_ST_COUNT;
        end
      end
      TMW_ST_ARMED: begin
        if (guard) begin
          st_d = TMW_ST_COUNT;
        end else if (!run) begin
          st_d = TMW_ST_IDLE;
        end else if (fall) begin
          st_d = TMW_ST_COUNT;
        end
      end
      TMW_ST_COUNT: begin
        if (!active) begin
          st_d = TMW_ST_IDLE;
        end
      end
      default: st_d = TMW_ST_IDLE;
    endcase
  end

  // Counter, prescaler and reload constant next values.
  // Priority: a reload (key, retrigger or end of count) beats everything else in the same cycle except a prescaler write, which still sets the prescaler count.
  // A stopped counter holds its value; a pending constant is taken when counting restarts.
  // The pending flag is cleared by any reload, so a constant is never applied twice.
  // Constant writes are refused in watchdog mode, so a runaway program cannot stretch the timeout.
  always_comb begin
    const_d = const_q;
    const_new_d = const_new_q;
    if (!guard && !hw_guard_q) begin
      if (wr_cnth) begin
        const_d[15:8] = i_reg_wdata;
        const_new_d = 1'b1;
      end
      if (wr_cntl) begin
        const_d[7:0] = i_reg_wdata;
        const_new_d = 1'b1;
      end
    end
    cnt_d = cnt_q;
    pre_cnt_d = pre_cnt_q;
    if (refresh || retrig || eoc) begin
      cnt_d = const_q;
      pre_cnt_d = pre_q;
      const_new_d = 1'b0;
    end else if (!active && st_d == TMW_ST_COUNT) begin
      cnt_d = cnt_q;
    end else if (st_q == TMW_ST_IDLE && st_d != TMW_ST_IDLE && const_new_q) begin
      cnt_d = const_q;
      const_new_d = 1'b0;
    end else if (counting && src_tick) begin
      pre_cnt_d = pre_done ? pre_q : pre_cnt_q - 8'h01;
      if (pre_done) begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
  end

  // Control register: software write, then single-mode end of count clears run.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = i_reg_wdata;
    end
    if (eoc && !guard && ctrl_q[`TMW_CTRL_SINGLE]) begin
      ctrl_d[`TMW_CTRL_RUN] = 1'b0;
    end
  end

  // Read mux; unmapped addresses read as zero.
  // Bits of shared registers that belong to other blocks also read as zero here.
  wire logic [7:0] rd_mux =
    hit(i_reg_addr, `TMW_ADDR_CNTH) ? cnt_q[15:8] :
    hit(i_reg_addr, `TMW_ADDR_CNTL) ? cnt_q[7:0] :
    hit(i_reg_addr, `TMW_ADDR_PRE) ? pre_q :
    hit(i_reg_addr, `TMW_ADDR_CTRL) ? ctrl_q :
    hit(i_reg_addr, `TMW_ADDR_WAIT) ? {1'b0, gen_n_q, 6'h00} :
    hit(i_reg_addr, `TMW_ADDR_EXT_IRQ_VECTOR_REG) ? {5'h00, ext_irq_vector_reg_q, 1'b0} :
    hit(i_reg_addr, `TMW_ADDR_FLAG) ? {1'b0, gres_q, 6'h00} : 8'h00;

  // Output pin level for the current end of count.
  // While enabled, the pin only moves at an end of count, so software may change the write-out bit at any time.
  wire logic out_d = !ctrl_q[`TMW_CTRL_OUTPUT_ENABLE_BIT] ? 1'b1 :
                     !eoc ? out_q :
                     ctrl_q[`TMW_CTRL_OUTPUT_MODE_BIT] ? ctrl_q[`TMW_CTRL_WRITE_OUT_BIT] :
                     !out_q;

  // Strap capture only on external reset; soft and watchdog resets leave it.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hw_guard_q <= 1'b0;
    end else begin
      hw_guard_q <= hw_guard_d;
    end
  end

  // Registered copy of the mode, built from next values so that it never lags the internal mode.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      guard_q <= 1'b0;
    end else begin
      guard_q <= hw_guard_d || !gen_n_d;
    end
  end

  // Main registers. The halt request is deliberately not used: the watchdog keeps running.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      const_q <= `TMW_RST_CNT;
      const_new_q <= 1'b0;
      cnt_q <= `TMW_RST_CNT;
      pre_q <= `TMW_RST_PRE;
      pre_cnt_q <= `TMW_RST_PRE;
      div_q <= 2'h0;
      ctrl_q <= `TMW_RST_CTRL;
      st_q <= TMW_ST_IDLE;
      pin_q <= 1'b1;
      out_q <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      const_q <= hw_guard_q ? `TMW_RST_CNT : const_d;
      const_new_q <= const_new_d;
      cnt_q <= cnt_d;
      pre_q <= wr_pre ? i_reg_wdata : pre_q;
      pre_cnt_q <= wr_pre ? i_reg_wdata : pre_cnt_d;
      div_q <= div_q + 2'h1;
      ctrl_q <= ctrl_d;
      st_q <= st_d;
      pin_q <= i_event_input_pin;
      out_q <= out_d;
      rdata_q <= i_reg_rd ? rd_mux : rdata_q;
    end
  end

  // Watchdog enable, key, interrupt routing and reset flag.
  // Interrupts are one-cycle pulses; the top level is raised only when channel A0 is not taking the timer.
  // The reset flag set wins over a clear in the same cycle, so a watchdog reset is never lost.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gen_n_q <= 1'b1;
      ext_irq_vector_reg_q <= 2'(`TMW_RST_EXT_IRQ_VECTOR_REG >> 1);
      key_armed_q <= 1'b0;
      irq_a0_q <= 1'b0;
      irq_tl_q <= 1'b0;
      sys_rst_q <= 1'b0;
      gres_q <= 1'b0;
    end else begin
      gen_n_q <= gen_n_d;
      ext_irq_vector_reg_q <= wr_ext_irq_vector_reg ? i_reg_wdata[`TMW_EXT_IRQ_VECTOR_REG_TLS:`TMW_EXT_IRQ_VECTOR_REG_A0S] : ext_irq_vector_reg_q;
      key_armed_q <= wr_cntl ? (i_reg_wdata == `TMW_KEY_ARM) : key_armed_q;
      irq_a0_q <= eoc && !guard && !ext_irq_vector_reg_q[`TMW_EXT_IRQ_VECTOR_REG_A0S];
      irq_tl_q <= eoc && !guard && !ext_irq_vector_reg_q[`TMW_EXT_IRQ_VECTOR_REG_TLS] && ext_irq_vector_reg_q[`TMW_EXT_IRQ_VECTOR_REG_A0S];
      sys_rst_q <= eoc && guard;
      gres_q <= (eoc && guard) ? 1'b1 : (i_ext_rst ? 1'b0 : gres_q);
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_timer_output_pin = out_q;
  assign o_irq_channel_a0 = irq_a0_q;
  assign o_irq_top_level = irq_tl_q;
  assign o_sys_reset = sys_rst_q;
  assign o_guard_mode = guard_q;

endmodule // tmw_timer_watchdog_unit

/* verif/tmw_unit_monitor.sv */
// Port-level assertion checker for the timer watchdog unit.
`timescale 1ns/1ps
module tmw_unit_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ext_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_event_input_pin,
  input wire logic i_guard_strap_pin,
  input wire logic i_halt_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_timer_output_pin,
  input wire logic o_irq_channel_a0,
  input wire logic o_irq_top_level,
  input wire logic o_sys_reset,
  input wire logic o_guard_mode
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // A refresh is two back-to-back writes of the key pair to the low counter byte.
  sequence seq_key_arm;
    i_reg_wr && i_reg_addr == 8'hF9 && i_reg_wdata == 8'hAA;
  endsequence
  sequence seq_key_fire;
    i_reg_wr && i_reg_addr == 8'hF9 && i_reg_wdata == 8'h55;
  endsequence
  // A fresh reload must keep the reset quiet for the next eight cycles.
  a_refresh_holds_off: assert property (o_guard_mode ##0 seq_key_arm ##1 seq_key_fire |=> !o_sys_reset [*8])
    else $error("system reset right after refresh");
  a_reset_one_cycle: assert property (o_sys_reset |=> !o_sys_reset)
    else $error("system reset longer than one cycle");
  a_reset_needs_guard: assert property (o_sys_reset |-> o_guard_mode)
    else $error("system reset outside watchdog mode");
  a_guard_stays_on: assert property (o_guard_mode && !i_ext_rst |=> o_guard_mode)
    else $error("watchdog mode left without reset");
  a_strap_sets_guard: assert property ($fell(i_ext_rst) && !i_guard_strap_pin |-> o_guard_mode)
    else $error("strap low did not enable watchdog");
  a_irq_timer_only: assert property (o_irq_channel_a0 |-> !o_guard_mode)
    else $error("channel interrupt in watchdog mode");
  a_irq_not_both: assert property (!(o_irq_channel_a0 && o_irq_top_level))
    else $error("both interrupts at once");
  a_irq_one_cycle: assert property (o_irq_channel_a0 |=> !o_irq_channel_a0)
    else $error("channel interrupt longer than one cycle");
  a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // tmw_unit_monitor

/* verif/tmw_far_side.sv */
// Far-side model: event pin driver and counter of system resets.
`timescale 1ns/1ps
module tmw_far_side (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_hold_low,
  input wire logic i_pulse,
  input wire logic i_sys_reset,
  output logic o_event_pin,
  output logic [7:0] o_reset_count
);
  logic [2:0] phase_q;
  // An event is four clocks low then four high, so falling edges stay eight clocks apart.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      phase_q <= 3'h0;
      o_reset_count <= 8'h00;
    end else begin
      if (i_pulse && phase_q == 3'h0) phase_q <= 3'h1;
      else if (phase_q != 3'h0) phase_q <= phase_q + 3'h1;
      if (i_sys_reset) o_reset_count <= o_reset_count + 8'h01;
    end
  end
  // The pin has a pull-up, so it idles high between events.
  assign o_event_pin = !(i_hold_low || (phase_q != 3'h0 && phase_q <= 3'h4));
endmodule // tmw_far_side

/* verif/tb_top.sv */
// Self-checking testbench for the timer watchdog unit.
`timescale 1ns/1ps
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_ext_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_event_input_pin, i_guard_strap_pin = 1'b1, i_halt_req = 1'b0, hold_low = 1'b0, pulse = 1'b0;
  logic [7:0] o_reg_rdata, rst_count, va, vb;
  logic o_timer_output_pin, o_irq_channel_a0, o_irq_top_level, o_sys_reset, o_guard_mode, p;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  tmw_timer_watchdog_unit i_dut (.i_clk_sys, .i_rst, .i_ext_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .i_event_input_pin, .i_guard_strap_pin, .i_halt_req, .o_reg_rdata, .o_timer_output_pin, .o_irq_channel_a0,
    .o_irq_top_level, .o_sys_reset, .o_guard_mode);
  tmw_far_side i_far (.i_clk_sys, .i_rst, .i_hold_low(hold_low), .i_pulse(pulse), .i_sys_reset(o_sys_reset),
    .o_event_pin(i_event_input_pin), .o_reset_count(rst_count));
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // A hang is cut short well beyond the longest expected run.
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    idle(1);
    i_reg_wr = 1'b0;
    idle(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    idle(1);
    i_reg_rd = 1'b0;
    idle(1);
    v = o_reg_rdata;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk8(n, e, v);
  endtask
  // Keys go out back to back with the strobe held, as the monitor's refresh check expects.
  task automatic refresh();
    i_reg_wr = 1'b1;
    i_reg_addr = 8'hF9;
    i_reg_wdata = 8'hAA;
    idle(1);
    i_reg_wdata = 8'h55;
    idle(1);
    i_reg_wr = 1'b0;
    idle(1);
  endtask
  task automatic wait_irq(input logic top);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 200 && !seen; n++) begin
      @(posedge i_clk_sys);
      #1;
      seen = top ? o_irq_top_level === 1'b1 : o_irq_channel_a0 === 1'b1;
    end
    #1;
    chk8(top ? "irq_top" : "irq_a0", 8'h01, {7'h00, seen});
  endtask
  task automatic ev();
    pulse = 1'b1;
    idle(1);
    pulse = 1'b0;
    idle(10);
  endtask
  task automatic t_reset_values();
    chk8("pin_idle", 8'h01, {7'h00, o_timer_output_pin});
    rdchk("cnt_hi", 8'hF8, 8'hFF);
    rdchk("cnt_lo", 8'hF9, 8'hFF);
    rdchk("prescale", 8'hFA, 8'hFF);
    rdchk("ctrl", 8'hFB, 8'h12);
    rdchk("unmapped", 8'h00, 8'h00);
  endtask
  task automatic t_single_square();
    wr(8'hF6, 8'h04);
    wr(8'hFA, 8'h00);
    wr(8'hF8, 8'h00);
    wr(8'hF9, 8'h03);
    wr(8'hFB, 8'hC1);
    p = o_timer_output_pin;
    wait_irq(1'b0);
    idle(2);
    chk8("square", {7'h00, ~p}, {7'h00, o_timer_output_pin});
    rdchk("ctrl_single", 8'hFB, 8'h41);
  endtask
  task automatic t_pwm_cont();
    wr(8'hFB, 8'h85);
    wait_irq(1'b0);
    idle(2);
    chk8("pwm", 8'h00, {7'h00, o_timer_output_pin});
    wait_irq(1'b0);
    wr(8'hF6, 8'h02);
    wait_irq(1'b1);
    rdchk("ctrl_cont", 8'hFB, 8'h85);
    wr(8'hFB, 8'h00);
    idle(2);
    chk8("pin_off", 8'h01, {7'h00, o_timer_output_pin});
  endtask
  task automatic t_event_gated();
    wr(8'hF9, 8'h10);
    wr(8'hFB, 8'h88);
    rd(8'hF9, va);
    idle(30);
    rdchk("no_event", 8'hF9, va);
    ev();
    ev();
    rd(8'hF9, va);
    ev();
    ev();
    rdchk("events", 8'hF9, va - 8'h02);
    wr(8'hFB, 8'h98);
    hold_low = 1'b1;
    rd(8'hF9, va);
    idle(20);
    rdchk("gate_low", 8'hF9, va);
    hold_low = 1'b0;
    idle(40);
    rd(8'hF9, vb);
    chk8("gate_high", 8'h01, {7'h00, vb != va});
    wr(8'hFB, 8'h00);
  endtask
  task automatic t_trig_retrig();
    wr(8'hF9, 8'h30);
    wr(8'hFB, 8'hA8);
    rd(8'hF9, va);
    idle(20);
    rdchk("trig_wait", 8'hF9, va);
    ev();
    rd(8'hF9, vb);
    chk8("trig_run", 8'h01, {7'h00, vb != va});
    wr(8'hFB, 8'hB8);
    idle(20);
    ev();
    rd(8'hF9, va);
    chk8("retrig", 8'h01, {7'h00, va >= 8'h2C});
    wr(8'hFB, 8'h38);
    rd(8'hF9, va);
    ev();
    rdchk("retrig_stop", 8'hF9, va);
  endtask
  task automatic t_watchdog();
    wr(8'hF8, 8'h00);
    wr(8'hF9, 8'h40);
    i_halt_req = 1'b1;
    wr(8'hFC, 8'h3F);
    chk8("guard_on", 8'h01, {7'h00, o_guard_mode});
    refresh();
    wr(8'hFC, 8'h7F);
    rd(8'hFC, va);
    chk8("wait_reg", 8'h00, va & 8'h40);
    repeat (4) begin
      idle(150);
      refresh();
    end
    chk8("no_reset", 8'h00, rst_count);
    for (int n = 0; n < 400 && rst_count == 8'h00; n++) idle(1);
    chk8("timeout", 8'h01, rst_count);
    rd(8'hF2, va);
    chk8("flag_set", 8'h40, va & 8'h40);
  endtask
  task automatic t_strap();
    i_guard_strap_pin = 1'b0;
    i_rst = 1'b1;
    i_ext_rst = 1'b1;
    idle(2);
    i_rst = 1'b0;
    idle(1);
    i_ext_rst = 1'b0;
    idle(1);
    chk8("strap", 8'h01, {7'h00, o_guard_mode});
    rd(8'hF2, va);
    chk8("flag_clr", 8'h00, va & 8'h40);
  endtask
  // Reset for five cycles, then release the external reset one cycle later.
  initial begin
    idle(5);
    i_rst = 1'b0;
    idle(1);
    i_ext_rst = 1'b0;
    idle(1);
    t_reset_values();
    t_single_square();
    t_pwm_cont();
    t_event_gated();
    t_trig_retrig();
    t_watchdog();
    t_strap();
    conclude();
  end
endmodule // tb_top
bind tmw_timer_watchdog_unit tmw_unit_monitor i_mon (.i_clk_sys, .i_rst, .i_ext_rst, .i_reg_wr, .i_reg_rd,
  .i_reg_addr, .i_reg_wdata, .i_event_input_pin, .i_guard_strap_pin, .i_halt_req, .o_reg_rdata,
  .o_timer_output_pin, .o_irq_channel_a0, .o_irq_top_level, .o_sys_reset, .o_guard_mode);
